// ### rtl/swic_regs.vh
// register offsets, field positions, reset values and timing counts of the coalescer
`ifndef SWIC_REGS_VH
`define SWIC_REGS_VH
`define SWIC_CTRL_OFS 12'h030
`define SWIC_STAT_OFS 12'h034
`define SWIC_CIE_BIT 12
`define SWIC_GIE_BIT 13
`define SWIC_THR_LSB 16
`define SWIC_THR_MSB 23
`define SWIC_DLY_LSB 24
`define SWIC_DLY_MSB 31
`define SWIC_THR_RST 8'h01
`define SWIC_DLY_RST 8'h00
`define SWIC_THR_MIN 8'h01
`define SWIC_UNIT_CYC 125
`define SWIC_UNIT_W 7
`define SWIC_CTRL_WMASK 32'hffff3000
`endif

// ### rtl/swic_gap_timer.v
// packet gap delay timer counting units of scatter-gather clock cycles
`timescale 1ns/10ps
`include "swic_regs.vh"
module swic_gap_timer #(
    parameter UNIT_CYC = `SWIC_UNIT_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // control
    input wire [7:0] units,
    input wire startPulse,
    input wire clearPulse,
    // result
    output reg expired
);
    reg running_q;
    reg [6:0] preCnt_q;
    reg [7:0] unitCnt_q;
    // compared at full width so the parameter is never sliced
    wire unitEnd = ({25'h0, preCnt_q} == UNIT_CYC - 1);
    wire lastUnit = (unitCnt_q == units - 8'h01);

    // prescaler and unit counter, restarted by startPulse and stopped by clearPulse
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            running_q <= 1'b0;
            preCnt_q <= 7'h00;
            unitCnt_q <= 8'h00;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (clearPulse || units == 8'h00) begin
                running_q <= 1'b0;
                preCnt_q <= 7'h00;
                unitCnt_q <= 8'h00;
            end else if (startPulse) begin
                running_q <= 1'b1;
                preCnt_q <= 7'h00;
                unitCnt_q <= 8'h00;
            end else if (running_q) begin
                if (unitEnd) begin
                    preCnt_q <= 7'h00;
                    if (lastUnit) begin
                        // 125 * units cycles have passed
                        expired <= 1'b1;
                        running_q <= 1'b0;
                        unitCnt_q <= 8'h00;
                    end else begin
                        unitCnt_q <= unitCnt_q + 8'h01;
                    end
                end else begin
                    preCnt_q <= preCnt_q + 7'h01;
                end
            end
        end
    end
endmodule // swic_gap_timer

// ### rtl/swic_coalesce.v
// stream write channel interrupt coalescing with apb control register
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "swic_regs.vh"
module swic_coalesce #(
    parameter SG_PRESENT = 1
) (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // channel events, one-cycle pulses on core_clk
    input wire completionEvent,
    input wire packetStart,
    input wire packetEnd,
    // interrupt pulses toward status logic
    output reg countIrq,
    output reg gapIrq
);
    // control word fields held as separate flops
    reg cieBit_q;
    reg gieBit_q;
    reg [7:0] thr_q;
    reg [7:0] dly_q;
    // completion countdown and interrupt state
    reg [7:0] remain_q;
    reg [7:0] remain_d;
    reg countIrq_d;
    reg gapIrq_d;
    reg [7:0] statLast_q;
    reg [7:0] statLast_d;
    // apb answer, chosen during setup
    reg [31:0] rdWord;
    reg pready_d;
    reg pslverr_d;
    // bus phase and address decode
    wire setup;
    wire access;
    wire ctrlWr;
    wire ctrlRd;
    wire statRd;
    wire [31:0] wrMasked;
    wire thrWrOk;
    // event qualification and timer hookup
    wire sgOn;
    wire doneEv;
    wire loadGroup;
    wire lastOfGroup;
    wire [7:0] timerUnits;
    wire timerStart;
    wire timerClear;
    wire gapExpired;
    // register images as software reads them
    wire [31:0] ctrlWord;
    wire [31:0] statWord;

    // true for the control word address
    function isCtrl;
        input [11:0] a;
        begin
            isCtrl = (a == `SWIC_CTRL_OFS);
        end
    endfunction

    // true for the status word address
    function isStat;
        input [11:0] a;
        begin
            isStat = (a == `SWIC_STAT_OFS);
        end
    endfunction

    // address decode used by the error path
    function known;
        input [11:0] a;
        begin
            known = isCtrl(a) || isStat(a);
        end
    endfunction

    // a threshold below the minimum would stall the countdown
    function thrLegal;
        input [7:0] v;
        begin
            thrLegal = (v >= `SWIC_THR_MIN);
        end
    endfunction

    // threshold field of a written word
    function [7:0] thrOf;
        input [31:0] w;
        begin
            thrOf = w[`SWIC_THR_MSB:`SWIC_THR_LSB];
        end
    endfunction

    // delay field of a written word
    function [7:0] dlyOf;
        input [31:0] w;
        begin
            dlyOf = w[`SWIC_DLY_MSB:`SWIC_DLY_LSB];
        end
    endfunction

    // one completion step of the countdown
    function [7:0] stepDown;
        input [7:0] cur;
        begin
            stepDown = cur - 8'h01;
        end
    endfunction

    // assembles the control word from its fields
    function [31:0] packCtrl;
        input [7:0] dlyF;
        input [7:0] thrF;
        input gieF;
        input cieF;
        begin
            packCtrl = {dlyF, thrF, 2'b00, gieF, cieF, 12'h000};
        end
    endfunction

    // assembles the status word, upper half reads zero
    function [31:0] packStat;
        input [7:0] lastF;
        input [7:0] remainF;
        begin
            packStat = {16'h0000, lastF, remainF};
        end
    endfunction

    // bus phase decode; reads and writes need no wait state
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign ctrlWr = access && pwrite && isCtrl(paddr);
    assign ctrlRd = setup && !pwrite && isCtrl(paddr);
    assign statRd = setup && !pwrite && isStat(paddr);
    assign wrMasked = pwdata & `SWIC_CTRL_WMASK;
    // zero would stall the countdown, so it is refused
    assign thrWrOk = thrLegal(thrOf(pwdata));

    // without scatter-gather both mechanisms stay idle
    assign sgOn = (SG_PRESENT != 0);
    assign doneEv = completionEvent && sgOn;
    assign loadGroup = ctrlWr && thrWrOk;
    assign lastOfGroup = doneEv && (remain_q <= 8'h01);
    assign timerUnits = sgOn ? dly_q : 8'h00;
    assign timerStart = packetEnd;
    assign timerClear = packetStart;

    // register images; unimplemented bits read zero
    assign ctrlWord = packCtrl(dly_q, thr_q, gieBit_q, cieBit_q);
    assign statWord = packStat(statLast_q, remain_q);

    // read data chosen during setup so it stands in the access cycle
    always @* begin
        rdWord = 32'h00000000;
        if (ctrlRd)
            rdWord = ctrlWord;
        else if (statRd)
            rdWord = statWord;
    end

    // ready follows every setup, error only for unmapped words
    always @* begin
        pready_d = setup;
        pslverr_d = setup && !known(paddr);
    end

    // ready answer register
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
        end else begin
            pready <= pready_d;
        end
    end

    // error answer register
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= pslverr_d;
        end
    end

    // read data register, zero outside read answers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= rdWord;
        end
    end

    // completion interrupt enable
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cieBit_q <= 1'b0;
        end else if (ctrlWr) begin
            cieBit_q <= wrMasked[`SWIC_CIE_BIT];
        end
    end

    // delay interrupt enable
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gieBit_q <= 1'b0;
        end else if (ctrlWr) begin
            gieBit_q <= wrMasked[`SWIC_GIE_BIT];
        end
    end

    // threshold field; a zero write leaves it as it was
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            thr_q <= `SWIC_THR_RST;
        end else if (loadGroup) begin
            // the other fields of the same write still land
            thr_q <= thrOf(pwdata);
        end
    end

    // delay field, any value accepted
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_q <= `SWIC_DLY_RST;
        end else if (ctrlWr) begin
            dly_q <= dlyOf(pwdata);
        end
    end

    // countdown; a threshold write restarts the group
    always @* begin
        remain_d = remain_q;
        if (loadGroup) begin
            remain_d = thrOf(pwdata);
        end else if (lastOfGroup) begin
            // this event ends the group, so the count reloads from thr_q
            remain_d = thr_q;
        end else if (doneEv) begin
            remain_d = stepDown(remain_q);
        end
    end

    // threshold interrupt; a threshold write in the same cycle drops the event
    always @* begin
        countIrq_d = 1'b0;
        if (lastOfGroup && !loadGroup)
            countIrq_d = cieBit_q;
    end

    // delay expiry reaches the gapIrq pulse only when enabled; the last cause records it either way
    always @* begin
        gapIrq_d = gapExpired && gieBit_q && sgOn;
    end

    // last cause, kept until the next interrupt event
    always @* begin
        statLast_d = statLast_q;
        if (countIrq_d || gapExpired)
            statLast_d = {6'h00, gapExpired, countIrq_d};
    end

    // countdown register
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remain_q <= `SWIC_THR_RST;
        end else begin
            remain_q <= remain_d;
        end
    end

    // threshold interrupt pulse
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            countIrq <= 1'b0;
        end else begin
            countIrq <= countIrq_d;
        end
    end

    // delay interrupt pulse, one cycle behind the expiry
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gapIrq <= 1'b0;
        end else begin
            gapIrq <= gapIrq_d;
        end
    end

    // last cause register
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            statLast_q <= 8'h00;
        end else begin
            statLast_q <= statLast_d;
        end
    end

    // delay timer, counting units of 125 clocks
    swic_gap_timer #(
        .UNIT_CYC(`SWIC_UNIT_CYC)
    ) u_gap (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .units(timerUnits),
        .startPulse(timerStart),
        .clearPulse(timerClear),
        .expired(gapExpired)
    );
endmodule // swic_coalesce

// ### dv/swic_coalesce_asserts.sv
// checker for the coalescer apb answer and interrupt pulses
`timescale 1ns/10ps
`include "swic_regs.vh"
module swic_coalesce_asserts (
    // clock, reset and apb
    input wire core_clk, rst_b, psel, penable, pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire pready, pslverr,
    // events and interrupts
    input wire completionEvent, packetStart, packetEnd, countIrq, gapIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // apb setup phase, and a setup that reads the control word
    sequence setupS; psel && !penable; endsequence
    sequence ctrlReadS; setupS ##0 (!pwrite && paddr == `SWIC_CTRL_OFS); endsequence
    a_answer_next: assert property (setupS |=> pready) else $error("no ready after setup");
    a_ready_quiet: assert property (!psel |=> !pready) else $error("ready without select");
    a_err_unmapped: assert property (setupS ##0 (paddr != `SWIC_CTRL_OFS &&
        paddr != `SWIC_STAT_OFS) |=> pslverr) else $error("unmapped not refused");
    a_err_mapped: assert property (setupS ##0 (paddr == `SWIC_CTRL_OFS ||
        paddr == `SWIC_STAT_OFS) |=> !pslverr) else $error("mapped refused");
    a_thr_nonzero: assert property (ctrlReadS |=> prdata[23:16] != 8'h00)
        else $error("threshold read zero");
    a_rsvd_zero: assert property (ctrlReadS |=> prdata[15:14] == 2'h0 && prdata[11:0] == 12'h0)
        else $error("reserved bits not zero");
    a_count_cause: assert property (countIrq |-> $past(completionEvent))
        else $error("count pulse without event");
    a_gap_single: assert property (gapIrq |=> !gapIrq) else $error("gap pulse too long");
    a_gap_cancel: assert property (packetStart |-> ##2 !gapIrq [*8])
        else $error("gap pulse after packet start");
endmodule // swic_coalesce_asserts
bind swic_coalesce swic_coalesce_asserts u_swic_coalesce_asserts (.*);

// ### dv/swic_coalesce_test.sv
// self-checking bench for the coalescer control word and interrupts
`timescale 1ns/10ps
`include "swic_regs.vh"
module swic_coalesce_test;
    reg core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rdErr;
    reg completionEvent = 0, packetStart = 0, packetEnd = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rdData, ctrlExp, seed = 32'd73553;
    reg [7:0] t, d;
    wire [31:0] prdata;
    wire pready, pslverr, countIrq, gapIrq;
    integer bad_count = 0, comparisons = 0, cntIrqs = 0, gapIrqs = 0, n, i, k;
    swic_coalesce u_swic_coalesce (.*);
    // clock, and pulse tallies kept off the main thread
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cntIrqs <= cntIrqs + countIrq;
        gapIrqs <= gapIrqs + gapIrq;
    end
    function [31:0] rnd(input [31:0] s);
        rnd = s ^ (s << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
    endfunction
    // zero threshold keeps the stored one
    function [31:0] nextCtrl(input [31:0] old, input [31:0] wr);
        nextCtrl = wr & `SWIC_CTRL_WMASK;
        if (wr[23:16] == 8'h00) nextCtrl[23:16] = old[23:16];
    endfunction
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] dat);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count = bad_count + 1;
            test_done;
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task ev(input [2:0] m);
        @(posedge core_clk);
        {completionEvent, packetStart, packetEnd} <= m;
        @(posedge core_clk);
        {completionEvent, packetStart, packetEnd} <= 3'b000;
    endtask
    task wr(input [31:0] dat);
        apb(1, `SWIC_CTRL_OFS, dat);
        ctrlExp = nextCtrl(ctrlExp, dat);
        apb(0, `SWIC_CTRL_OFS, 0);
        chk(rdData, ctrlExp, "control");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1;
        ctrlExp = {`SWIC_DLY_RST, `SWIC_THR_RST, 16'h0000};
        apb(0, `SWIC_CTRL_OFS, 0);
        chk(rdData, ctrlExp, "reset value");
        apb(0, 12'h0f0, 0);
        chk(rdErr, 1, "unmapped error");
        // random control words, one with a zero threshold
        for (i = 0; i < 6; i = i + 1) begin
            seed = rnd(seed);
            wr(i == 1 ? seed & 32'hff00ffff : seed);
        end
        // threshold counting, enabled then masked
        for (i = 0; i < 2; i = i + 1) begin
            seed = rnd(seed);
            t = seed[1:0] + 1;
            wr({8'h00, t, 3'b000, i == 0, 12'h000});
            k = cntIrqs;
            repeat (t - 1) ev(3'b100);
            repeat (2) @(posedge core_clk);
            chk(cntIrqs - k, 0, "early count irq");
            repeat (t + 1) ev(3'b100);
            repeat (2) @(posedge core_clk);
            chk(cntIrqs - k, i ? 0 : 2, "count irqs");
        end
        // gap timer: fire, zero delay, masked, cancelled
        for (i = 0; i < 4; i = i + 1) begin
            seed = rnd(seed);
            d = (i == 1) ? 8'h00 : seed[0] + 1;
            wr({d, 8'h01, 2'b00, i != 2, 13'h0000});
            ev(3'b001);
            if (i == 3) ev(3'b010);
            n = 0;
            while (gapIrq !== 1'b1 && n < 300) begin
                @(posedge core_clk);
                n = n + 1;
            end
            chk(n, i ? 300 : 125 * d + 2, "gap delay");
        end
        // reset in mid-run brings the control word back
        rst_b <= 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1;
        ctrlExp = {`SWIC_DLY_RST, `SWIC_THR_RST, 16'h0000};
        apb(0, `SWIC_CTRL_OFS, 0);
        chk(rdData, ctrlExp, "reset again");
        test_done;
    end
endmodule // swic_coalesce_test
